// >>> dic_decode_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "dic_params.svh"
module dic_decode_monitor (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_instr_valid,
    input wire logic [`DIC_IW-1:0] i_instr,
    input wire logic o_ready,
    input wire logic o_valid,
    input var dic_pkg::dic_class_t o_class,
    input var dic_pkg::dic_unit_t o_unit,
    input wire logic o_mem_acc,
    input wire logic o_mem_store,
    input wire logic o_mem_space,
    input wire logic o_illegal
);
    import dic_pkg::*;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    logic take;
    logic [3:0] cls;
    assign take = i_instr_valid && o_ready;
    assign cls = i_instr[31:28];
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_take_branch;
        take && cls == 4'h6;
    endsequence
    sequence s_one_dead_cycle;
        !o_ready ##1 o_ready;
    endsequence
    sequence s_take_ls;
        take && cls == 4'h3;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    AST_BRANCH_STALL: assert property (s_take_branch |=> s_one_dead_cycle)
        else $error("branch did not stall exactly one cycle");
    AST_CLASS_OF_WORD: assert property (take && cls <= 4'h8 |=> o_valid && o_class == $past(cls))
        else $error("wrong class or missing valid");
    AST_NO_SPURIOUS_VALID: assert property (!take |=> !o_valid)
        else $error("valid without an accepted word");
    AST_UNDEF_CTL: assert property (take && cls > 4'h8 |=> o_class == DIC_CLS_CTL && o_illegal)
        else $error("undefined class not flagged");
    AST_TRI_MAC: assert property (o_valid && o_class == DIC_CLS_TRI && !o_illegal |-> o_unit == DIC_UNIT_MAC)
        else $error("three-operand word not on multiplier");
    AST_UNI_ALU: assert property (o_valid && o_class == DIC_CLS_UNI && !o_illegal |-> o_unit == DIC_UNIT_ALU)
        else $error("one-operand word not on arithmetic unit");
    AST_BIN_SHIFT: assert property (take && cls == 4'h1 && i_instr[27:26] == 2'h2 |=> o_unit == DIC_UNIT_SHIFT)
        else $error("shift variant not on shifter");
    AST_LS_DIR: assert property (s_take_ls |=> o_mem_acc |-> o_mem_store == $past(i_instr[17])
        && o_mem_space == $past(i_instr[10]))
        else $error("load/store direction or space wrong");
    AST_LS_SPACE: assert property (s_take_ls ##0 (i_instr[13:11] < 3'h6 && i_instr[16] != i_instr[10])
        |=> !o_mem_acc && o_illegal)
        else $error("pointer of other space accepted");
endmodule : dic_decode_monitor
bind dic_decode_top dic_decode_monitor u_dic_decode_monitor (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
    .i_instr_valid(i_instr_valid), .i_instr(i_instr), .o_ready(o_ready), .o_valid(o_valid), .o_class(o_class),
    .o_unit(o_unit), .o_mem_acc(o_mem_acc), .o_mem_store(o_mem_store), .o_mem_space(o_mem_space),
    .o_illegal(o_illegal));
`default_nettype wire

// >>> dic_decode_top.sv
// How it works
// - Each instruction arrives whole as one 32-bit word and is decoded from that word alone.
// - An instruction is taken every cycle, except that a branch holds the decoder for extra cycles.
// - Every word is put into exactly one of nine classes, undefined class codes going to control.
// - Three-operand words go to the multiply-accumulate unit with three register selectors.
// - Two-operand words go to the multiplier, arithmetic unit or shifter, optionally with an immediate input.
// - One-operand words go to the arithmetic unit with one register selector.
// - Load/store words move a 16-bit value between memory and any register in either direction.
// - Register transfer words name a source and a destination register.
// - Immediate-set words load a register or an address-generation register with the immediate.
// - Loop words hand a repeat count to the sequencer so no branch is needed.
// - Add-immediate modification works on all eight pointers, other modes only on the space's own four.
// - An indirect access addresses memory with the selected pointer's present contents, bit-reversed in reverse-step mode.
// - A pointer is modified after its access and the next instruction sees the new value.
`timescale 1ns/100ps
`default_nettype none
`include "dic_params.svh"
module dic_decode_top (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_instr_valid,
    input wire logic [`DIC_IW-1:0] i_instr,
    output logic o_ready,
    output logic o_valid,
    output dic_pkg::dic_class_t o_class,
    output dic_pkg::dic_unit_t o_unit,
    output dic_pkg::dic_sel_t o_sel_dst,
    output dic_pkg::dic_sel_t o_sel_a,
    output dic_pkg::dic_sel_t o_sel_b,
    output logic o_use_imm,
    output logic [`DIC_DW-1:0] o_imm,
    output logic o_mem_acc,
    output logic o_mem_store,
    output logic o_mem_space,
    output logic [`DIC_DW-1:0] o_mem_addr,
    output logic o_loop,
    output logic o_illegal
);
    import dic_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    typedef enum logic {
        DIC_ST_RUN = 1'b0,
        DIC_ST_WAIT = 1'b1
    } dic_state_t;

    dic_state_t state_r;
    dic_state_t state_nxt;
    logic [1:0] wait_r;
    logic take;
    dic_ptr_if ptr_bus ();

    dic_class_t cls_nxt;
    dic_unit_t unit_nxt;
    dic_sel_t dst_nxt;
    dic_sel_t a_nxt;
    dic_sel_t b_nxt;
    logic use_imm_nxt;
    logic [`DIC_DW-1:0] imm_nxt;
    logic mem_nxt;
    logic store_nxt;
    logic space_nxt;
    logic loop_nxt;
    logic bad_nxt;
    logic [3:0] cls_f;
    dic_sel_t f_sd;
    dic_sel_t f_sa;
    dic_sel_t f_sb;
    dic_sel_t f_is;
    logic [2:0] f_mod;
    logic [2:0] f_ptr;

    // A selector is good only when its part code names one of the five register views.
    function automatic logic sel_ok(input dic_sel_t s);
        return s.part <= `DIC_PART_MAX;
    endfunction : sel_ok

    assign take = i_instr_valid && o_ready;
    assign cls_f = i_instr[`DIC_CLS_HI:`DIC_CLS_LO];
    assign f_sd = i_instr[`DIC_SD_HI:`DIC_SD_LO];
    assign f_sa = i_instr[`DIC_SA_HI:`DIC_SA_LO];
    assign f_sb = i_instr[`DIC_SB_HI:`DIC_SB_LO];
    assign f_is = i_instr[`DIC_IS_SEL_HI:`DIC_IS_SEL_LO];
    assign f_mod = i_instr[`DIC_LS_MOD_HI:`DIC_LS_MOD_LO];
    assign f_ptr = i_instr[`DIC_LS_PTR_HI:`DIC_LS_PTR_LO];

    ////////////////////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        cls_nxt = DIC_CLS_CTL;
        unit_nxt = DIC_UNIT_NONE;
        dst_nxt = '0;
        a_nxt = '0;
        b_nxt = '0;
        use_imm_nxt = 1'b0;
        imm_nxt = '0;
        mem_nxt = 1'b0;
        store_nxt = 1'b0;
        space_nxt = 1'b0;
        loop_nxt = 1'b0;
        bad_nxt = 1'b0;
        case (cls_f)
            DIC_CLS_TRI: begin
                cls_nxt = DIC_CLS_TRI;
                unit_nxt = DIC_UNIT_MAC;
                dst_nxt = f_sd;
                a_nxt = f_sa;
                b_nxt = f_sb;
                bad_nxt = !(sel_ok(f_sd) && sel_ok(f_sa) && sel_ok(f_sb));
            end
            DIC_CLS_BIN: begin
                cls_nxt = DIC_CLS_BIN;
                dst_nxt = f_sd;
                a_nxt = f_sa;
                use_imm_nxt = i_instr[`DIC_BIMM_BIT];
                if (i_instr[`DIC_BIMM_BIT]) begin
                    imm_nxt = 16'(i_instr[`DIC_BIMM_HI:`DIC_BIMM_LO]);
                end else begin
                    b_nxt = f_sb;
                end
                case (i_instr[`DIC_OP_HI:`DIC_OP_HI-1])
                    2'h0: unit_nxt = DIC_UNIT_MAC;
                    2'h1: unit_nxt = DIC_UNIT_ALU;
                    2'h2: unit_nxt = DIC_UNIT_SHIFT;
                    default: bad_nxt = 1'b1;
                endcase
                if (!sel_ok(f_sd) || !sel_ok(f_sa) || (!i_instr[`DIC_BIMM_BIT] && !sel_ok(f_sb))) begin
                    bad_nxt = 1'b1;
                end
            end
            DIC_CLS_UNI: begin
                cls_nxt = DIC_CLS_UNI;
                unit_nxt = DIC_UNIT_ALU;
                dst_nxt = f_sd;
                bad_nxt = !sel_ok(f_sd);
            end
            DIC_CLS_LS: begin
                cls_nxt = DIC_CLS_LS;
                unit_nxt = DIC_UNIT_AGU;
                dst_nxt = f_sd;
                store_nxt = i_instr[`DIC_LS_DIR_BIT];
                space_nxt = i_instr[`DIC_LS_SPACE_BIT];
                imm_nxt = 16'(i_instr[`DIC_LS_IMM_HI:`DIC_LS_IMM_LO]);
                // Outside add-immediate, X owns pointers 0-3 and Y owns 4-7.
                bad_nxt = !sel_ok(f_sd) || f_mod > DIC_MOD_ADDIMM ||
                          (f_mod != DIC_MOD_ADDIMM && f_ptr[2] != i_instr[`DIC_LS_SPACE_BIT]);
                mem_nxt = !bad_nxt;
            end
            DIC_CLS_XFER: begin
                cls_nxt = DIC_CLS_XFER;
                dst_nxt = f_sd;
                a_nxt = f_sa;
                bad_nxt = !(sel_ok(f_sd) && sel_ok(f_sa));
            end
            DIC_CLS_IMM: begin
                cls_nxt = DIC_CLS_IMM;
                use_imm_nxt = 1'b1;
                imm_nxt = i_instr[`DIC_IS_IMM_HI:`DIC_IS_IMM_LO];
                if (i_instr[`DIC_IS_AGU_BIT]) begin
                    unit_nxt = DIC_UNIT_AGU;
                end else begin
                    dst_nxt = f_is;
                    bad_nxt = !sel_ok(f_is);
                end
            end
            DIC_CLS_BR: begin
                cls_nxt = DIC_CLS_BR;
                unit_nxt = DIC_UNIT_SEQ;
                use_imm_nxt = 1'b1;
                imm_nxt = i_instr[`DIC_IS_IMM_HI:`DIC_IS_IMM_LO];
            end
            DIC_CLS_LOOP: begin
                cls_nxt = DIC_CLS_LOOP;
                unit_nxt = DIC_UNIT_SEQ;
                loop_nxt = 1'b1;
                use_imm_nxt = 1'b1;
                imm_nxt = i_instr[`DIC_IS_IMM_HI:`DIC_IS_IMM_LO];
            end
            DIC_CLS_CTL: begin
                unit_nxt = DIC_UNIT_SEQ;
            end
            default: begin
                unit_nxt = DIC_UNIT_SEQ;
                bad_nxt = 1'b1;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Pointer traffic only for accepted, legal words, so a refused word never moves a pointer.
    assign ptr_bus.acc = take && mem_nxt;
    assign ptr_bus.ptr = f_ptr;
    assign ptr_bus.mode = dic_mod_t'(f_mod);
    assign ptr_bus.imm = imm_nxt;
    assign ptr_bus.wr = take && cls_nxt == DIC_CLS_IMM && i_instr[`DIC_IS_AGU_BIT];
    assign ptr_bus.kind = dic_agu_t'(i_instr[`DIC_IS_KIND_HI:`DIC_IS_KIND_LO]);
    assign ptr_bus.widx = i_instr[`DIC_IS_IDX_HI:`DIC_IS_IDX_LO];
    assign ptr_bus.wdata = imm_nxt;

    dic_ptr_unit u_ptr (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .io_ptr(ptr_bus)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            DIC_ST_RUN: begin
                if (take && cls_nxt == DIC_CLS_BR) begin
                    state_nxt = DIC_ST_WAIT;
                end
            end
            DIC_ST_WAIT: begin
                if (wait_r == 2'h0) begin
                    state_nxt = DIC_ST_RUN;
                end
            end
            default: state_nxt = DIC_ST_RUN;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            state_r <= DIC_ST_RUN;
            wait_r <= 2'h0;
            o_ready <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (state_r == DIC_ST_RUN) begin
                wait_r <= `DIC_BRANCH_WAIT - 2'h1;
            end else if (wait_r != 2'h0) begin
                wait_r <= wait_r - 2'h1;
            end
            o_ready <= state_nxt == DIC_ST_RUN;
        end
    end

    // Every decoded field is registered so the execution units see one clean word per cycle.
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            o_valid <= 1'b0;
            o_class <= DIC_CLS_CTL;
            o_unit <= DIC_UNIT_NONE;
            o_sel_dst <= '0;
            o_sel_a <= '0;
            o_sel_b <= '0;
            o_use_imm <= 1'b0;
            o_imm <= '0;
            o_mem_acc <= 1'b0;
            o_mem_store <= 1'b0;
            o_mem_space <= 1'b0;
            o_mem_addr <= '0;
            o_loop <= 1'b0;
            o_illegal <= 1'b0;
        end else begin
            o_valid <= take;
            if (take) begin
                o_class <= cls_nxt;
                o_unit <= unit_nxt;
                o_sel_dst <= dst_nxt;
                o_sel_a <= a_nxt;
                o_sel_b <= b_nxt;
                o_use_imm <= use_imm_nxt;
                o_imm <= imm_nxt;
                o_mem_acc <= mem_nxt;
                o_mem_store <= store_nxt;
                o_mem_space <= space_nxt;
                o_mem_addr <= ptr_bus.addr;
                o_loop <= loop_nxt;
                o_illegal <= bad_nxt;
            end
        end
    end
endmodule : dic_decode_top
`default_nettype wire

// >>> dic_fetch_model.sv
`timescale 1ns/100ps
`default_nettype none
module dic_fetch_model (
    input wire logic i_ref_clk,
    input wire logic i_ready,
    output var logic o_instr_valid,
    output var logic [31:0] o_instr
);
    logic [31:0] last_r;
    initial begin
        o_instr_valid = 1'b0;
        o_instr = 32'hFFFFFFFF;
        last_r = 32'h00000000;
    end
    // The word is held until the edge that samples ready high.
    task automatic send(input logic [31:0] w, output bit ok);
        ok = 1'b0;
        @(negedge i_ref_clk);
        o_instr_valid = 1'b1;
        o_instr = w;
        last_r = w;
        for (int n = 0; n < 16 && !ok; n++) begin
            @(posedge i_ref_clk);
            ok = (i_ready === 1'b1);
        end
    endtask : send
    // Released lines show the inverse of the last word, so a decoder that reads them is caught.
    task automatic idle();
        @(negedge i_ref_clk);
        o_instr_valid = 1'b0;
        o_instr = ~last_r;
    endtask : idle
endmodule : dic_fetch_model
`default_nettype wire

// >>> dic_params.svh
`ifndef DIC_PARAMS_SVH
`define DIC_PARAMS_SVH

// Word sizes and pointer count.
`define DIC_IW 32
`define DIC_DW 16
`define DIC_NPTR 8

// Class, operation and register-selector fields.
`define DIC_CLS_HI 31
`define DIC_CLS_LO 28
`define DIC_OP_HI 27
`define DIC_OP_LO 24
`define DIC_SD_HI 23
`define DIC_SD_LO 18
`define DIC_SA_HI 17
`define DIC_SA_LO 12
`define DIC_SB_HI 11
`define DIC_SB_LO 6

// Two-operand immediate substitution.
`define DIC_BIMM_BIT 5
`define DIC_BIMM_HI 4
`define DIC_BIMM_LO 0

// Load/store fields.
`define DIC_LS_DIR_BIT 17
`define DIC_LS_PTR_HI 16
`define DIC_LS_PTR_LO 14
`define DIC_LS_MOD_HI 13
`define DIC_LS_MOD_LO 11
`define DIC_LS_SPACE_BIT 10
`define DIC_LS_IMM_HI 9
`define DIC_LS_IMM_LO 0

// Immediate-set fields; the 16-bit immediate is shared with branch and loop.
`define DIC_IS_AGU_BIT 23
`define DIC_IS_SEL_HI 22
`define DIC_IS_SEL_LO 17
`define DIC_IS_KIND_HI 22
`define DIC_IS_KIND_LO 21
`define DIC_IS_IDX_HI 20
`define DIC_IS_IDX_LO 18
`define DIC_IS_IMM_HI 15
`define DIC_IS_IMM_LO 0

// Highest legal register part code.
`define DIC_PART_MAX 3'h4
// Extra cycles a branch holds the decoder.
`define DIC_BRANCH_WAIT 2'h1
// Reset value of every address register.
`define DIC_AGU_RST 16'h0000

`endif

// >>> dic_pkg.sv
package dic_pkg;
`include "dic_params.svh"

typedef enum logic [3:0] {
    DIC_CLS_TRI = 4'h0,
    DIC_CLS_BIN = 4'h1,
    DIC_CLS_UNI = 4'h2,
    DIC_CLS_LS = 4'h3,
    DIC_CLS_XFER = 4'h4,
    DIC_CLS_IMM = 4'h5,
    DIC_CLS_BR = 4'h6,
    DIC_CLS_LOOP = 4'h7,
    DIC_CLS_CTL = 4'h8
} dic_class_t;

typedef enum logic [2:0] {
    DIC_UNIT_NONE = 3'h0,
    DIC_UNIT_MAC = 3'h1,
    DIC_UNIT_ALU = 3'h2,
    DIC_UNIT_SHIFT = 3'h3,
    DIC_UNIT_AGU = 3'h4,
    DIC_UNIT_SEQ = 3'h5
} dic_unit_t;

typedef enum logic [2:0] {
    DIC_MOD_NONE = 3'h0,
    DIC_MOD_INC = 3'h1,
    DIC_MOD_DEC = 3'h2,
    DIC_MOD_STEP = 3'h3,
    DIC_MOD_MODULO = 3'h4,
    DIC_MOD_REVSTEP = 3'h5,
    DIC_MOD_ADDIMM = 3'h6
} dic_mod_t;

typedef enum logic [2:0] {
    DIC_PART_WHOLE = 3'h0,
    DIC_PART_LOW = 3'h1,
    DIC_PART_HIGH = 3'h2,
    DIC_PART_EXT = 3'h3,
    DIC_PART_EXTHIGH = 3'h4
} dic_part_t;

typedef struct packed {
    logic [2:0] part;
    logic [2:0] idx;
} dic_sel_t;

typedef enum logic [1:0] {
    DIC_AGU_DP = 2'h0,
    DIC_AGU_STEP = 2'h1,
    DIC_AGU_MODX = 2'h2,
    DIC_AGU_MODY = 2'h3
} dic_agu_t;

endpackage : dic_pkg

// >>> dic_ptr_if.sv
`timescale 1ns/100ps
`default_nettype none
`include "dic_params.svh"
interface dic_ptr_if;
    import dic_pkg::*;
    logic acc;
    logic [2:0] ptr;
    dic_mod_t mode;
    logic [`DIC_DW-1:0] imm;
    logic [`DIC_DW-1:0] addr;
    logic wr;
    dic_agu_t kind;
    logic [2:0] widx;
    logic [`DIC_DW-1:0] wdata;
    modport dec(output acc, output ptr, output mode, output imm, output wr, output kind, output widx,
                output wdata, input addr);
    modport agu(input acc, input ptr, input mode, input imm, input wr, input kind, input widx,
                input wdata, output addr);
endinterface : dic_ptr_if
`default_nettype wire

// >>> dic_ptr_unit.sv
`timescale 1ns/100ps
`default_nettype none
`include "dic_params.svh"
module dic_ptr_unit (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    dic_ptr_if.agu io_ptr
);
    import dic_pkg::*;

    logic [`DIC_DW-1:0] data_pointers_r [`DIC_NPTR];
    logic [`DIC_DW-1:0] pointer_step_regs_r [`DIC_NPTR];
    logic [`DIC_DW-1:0] modulo_limit_x_r;
    logic [`DIC_DW-1:0] modulo_limit_y_r;
    logic [`DIC_DW-1:0] cur;
    logic [`DIC_DW-1:0] step;
    logic [`DIC_DW-1:0] ptr_nxt;

    function automatic logic [`DIC_DW-1:0] bit_rev(input logic [`DIC_DW-1:0] v);
        logic [`DIC_DW-1:0] r;
        r = '0;
        for (int i = 0; i < `DIC_DW; i++) begin
            r[i] = v[`DIC_DW-1-i];
        end
        return r;
    endfunction : bit_rev

    // The ring spans limit+1 words; the base keeps the pointer inside its own ring.
    function automatic logic [`DIC_DW-1:0] mod_step(input logic [`DIC_DW-1:0] p, input logic [`DIC_DW-1:0] n,
                                                    input logic [`DIC_DW-1:0] m);
        logic [`DIC_DW:0] span;
        logic [`DIC_DW-1:0] low;
        logic [`DIC_DW-1:0] wrapped;
        span = {1'b0, m} + 17'h00001;
        low = 16'({1'b0, p} % span);
        wrapped = 16'(({1'b0, low} + {1'b0, n}) % span);
        return wrapped + (p - low);
    endfunction : mod_step

    assign cur = data_pointers_r[io_ptr.ptr];
    assign step = pointer_step_regs_r[io_ptr.ptr];

    // The access uses the pointer before modification.
    assign io_ptr.addr = (io_ptr.mode == DIC_MOD_REVSTEP) ? bit_rev(cur) : cur;

    always_comb begin
        case (io_ptr.mode)
            DIC_MOD_INC: ptr_nxt = cur + 16'h0001;
            DIC_MOD_DEC: ptr_nxt = cur - 16'h0001;
            DIC_MOD_STEP: ptr_nxt = cur + step;
            DIC_MOD_REVSTEP: ptr_nxt = cur + step;
            DIC_MOD_MODULO: ptr_nxt = mod_step(cur, step, io_ptr.ptr[2] ? modulo_limit_y_r : modulo_limit_x_r);
            DIC_MOD_ADDIMM: ptr_nxt = cur + io_ptr.imm;
            default: ptr_nxt = cur;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            for (int i = 0; i < `DIC_NPTR; i++) begin
                data_pointers_r[i] <= `DIC_AGU_RST;
            end
        end else if (io_ptr.wr && io_ptr.kind == DIC_AGU_DP) begin
            data_pointers_r[io_ptr.widx] <= io_ptr.wdata;
        end else if (io_ptr.acc) begin
            data_pointers_r[io_ptr.ptr] <= ptr_nxt;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            for (int i = 0; i < `DIC_NPTR; i++) begin
                pointer_step_regs_r[i] <= `DIC_AGU_RST;
            end
        end else if (io_ptr.wr && io_ptr.kind == DIC_AGU_STEP) begin
            pointer_step_regs_r[io_ptr.widx] <= io_ptr.wdata;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            modulo_limit_x_r <= `DIC_AGU_RST;
            modulo_limit_y_r <= `DIC_AGU_RST;
        end else if (io_ptr.wr && io_ptr.kind == DIC_AGU_MODX) begin
            modulo_limit_x_r <= io_ptr.wdata;
        end else if (io_ptr.wr && io_ptr.kind == DIC_AGU_MODY) begin
            modulo_limit_y_r <= io_ptr.wdata;
        end
    end
endmodule : dic_ptr_unit
`default_nettype wire

// >>> test_dic_decode_top.sv
`timescale 1ns/100ps
`default_nettype none
module test_dic_decode_top;
    import dic_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_instr_valid;
    logic [31:0] i_instr;
    logic o_ready, o_valid, o_use_imm, o_mem_acc, o_mem_store, o_mem_space, o_loop, o_illegal;
    dic_class_t o_class;
    dic_unit_t o_unit;
    dic_sel_t o_sel_dst, o_sel_a, o_sel_b;
    logic [15:0] o_imm, o_mem_addr;
    int n_mismatch = 0;
    int compares = 0;
    always #25 i_ref_clk = ~i_ref_clk;
    dic_decode_top u_dic_decode_top (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_instr_valid(i_instr_valid),
        .i_instr(i_instr), .o_ready(o_ready), .o_valid(o_valid), .o_class(o_class), .o_unit(o_unit),
        .o_sel_dst(o_sel_dst), .o_sel_a(o_sel_a), .o_sel_b(o_sel_b), .o_use_imm(o_use_imm), .o_imm(o_imm),
        .o_mem_acc(o_mem_acc), .o_mem_store(o_mem_store), .o_mem_space(o_mem_space),
        .o_mem_addr(o_mem_addr), .o_loop(o_loop), .o_illegal(o_illegal));
    dic_fetch_model u_dic_fetch_model (.i_ref_clk(i_ref_clk), .i_ready(o_ready),
        .o_instr_valid(i_instr_valid), .o_instr(i_instr));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input bit c, input string m);
        compares++;
        if (!c) begin
            n_mismatch++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask : chk
    // Outputs of a taken word are looked at just after the take edge, so back-to-back stays possible.
    task automatic issue(input logic [31:0] w);
        bit ok;
        u_dic_fetch_model.send(w, ok);
        if (!ok) begin
            n_mismatch++;
            $display("mismatch at %0t: word never taken", $time);
            give_verdict();
        end else begin
            #1;
            chk(o_valid === 1'b1, "valid");
        end
    endtask : issue
    function automatic logic [31:0] ls(input logic st, input logic [2:0] p, input logic [2:0] m,
        input logic sp, input logic [9:0] im);
        return {4'h3, 4'h0, 6'h01, st, p, m, sp, im};
    endfunction : ls
    function automatic logic [31:0] agu(input logic [1:0] k, input logic [2:0] x, input logic [15:0] v);
        return {4'h5, 4'h0, 1'b1, k, x, 2'h0, v};
    endfunction : agu
    task automatic lsa(input logic [31:0] w, input logic [15:0] a, input logic acc);
        issue(w);
        chk(o_mem_acc === acc && o_illegal === !acc, "access");
        if (acc) chk(o_mem_addr === a && o_mem_store === w[17] && o_mem_space === w[10], "address");
    endtask : lsa
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_classes();
        for (int c = 0; c < 16; c++) begin
            issue({c[3:0], 4'h4, 6'h01, 6'h0A, 6'h13, 6'h00});
            chk(o_class === (c < 9 ? c[3:0] : 4'h8), "class");
            if (c > 8) chk(o_illegal === 1'b1, "undefined class");
            if (c == 0) chk(o_unit === DIC_UNIT_MAC && o_sel_a === 6'h0A && o_sel_b === 6'h13, "tri");
            if (c == 2) chk(o_unit === DIC_UNIT_ALU && o_sel_dst === 6'h01, "uni");
            if (c == 4) chk(o_sel_dst === 6'h01 && o_sel_a === 6'h0A, "xfer");
            if (c == 5) chk(o_use_imm === 1'b1 && o_imm === 16'hA4C0 && o_sel_dst === 6'h02, "imm set");
            if (c == 7) chk(o_loop === 1'b1 && o_unit === DIC_UNIT_SEQ, "loop");
        end
        u_dic_fetch_model.idle();
        $display("test classes done");
    endtask : t_classes
    task automatic t_branch();
        time t0;
        issue(32'h60000123);
        chk(o_ready === 1'b0 && o_imm === 16'h0123, "branch stall");
        t0 = $time;
        issue(32'h00000000);
        chk($time - t0 == 100, "branch spacing");
        issue(32'h00000000);
        chk($time - t0 == 150, "back to back");
        u_dic_fetch_model.idle();
        $display("test branch done");
    endtask : t_branch
    task automatic t_bin();
        for (int u = 0; u < 3; u++) begin
            issue({4'h1, u[1:0], 2'h0, 6'h01, 6'h0A, 6'h00, 1'b1, 5'h1F});
            chk(o_unit === 3'(u + 1) && o_use_imm === 1'b1 && o_imm === 16'h001F, "bin unit");
        end
        issue({4'h1, 4'hC, 24'h0284C0});
        chk(o_illegal === 1'b1, "bin unit code 3");
        issue({4'h0, 4'h0, 6'h29, 6'h0A, 6'h13, 6'h00});
        chk(o_illegal === 1'b1, "part code 5");
        issue({4'h0, 4'h0, 6'h21, 6'h1A, 6'h1F, 6'h00});
        chk(o_illegal === 1'b0 && o_sel_dst === 6'h21 && o_sel_b === 6'h1F, "part codes");
        u_dic_fetch_model.idle();
        $display("test binomial done");
    endtask : t_bin
    // Accesses rely on pointer values left by earlier words or by reset, taken back to back.
    task automatic t_ptr();
        issue(agu(2'h0, 3'h3, 16'h1000));
        issue(agu(2'h1, 3'h3, 16'h0010));
        lsa(ls(1'b0, 3'h3, 3'h1, 1'b0, 10'h000), 16'h1000, 1'b1);
        lsa(ls(1'b1, 3'h3, 3'h3, 1'b0, 10'h000), 16'h1001, 1'b1);
        lsa(ls(1'b0, 3'h3, 3'h6, 1'b0, 10'h005), 16'h1011, 1'b1);
        lsa(ls(1'b0, 3'h3, 3'h1, 1'b1, 10'h000), 16'h0000, 1'b0);
        lsa(ls(1'b0, 3'h3, 3'h2, 1'b0, 10'h000), 16'h1016, 1'b1);
        lsa(ls(1'b1, 3'h3, 3'h0, 1'b0, 10'h000), 16'h1015, 1'b1);
        lsa(ls(1'b1, 3'h6, 3'h6, 1'b0, 10'h003), 16'h0000, 1'b1);
        lsa(ls(1'b0, 3'h6, 3'h0, 1'b1, 10'h000), 16'h0003, 1'b1);
        issue(agu(2'h2, 3'h0, 16'h0007));
        issue(agu(2'h1, 3'h3, 16'h0003));
        lsa(ls(1'b0, 3'h3, 3'h4, 1'b0, 10'h000), 16'h1015, 1'b1);
        lsa(ls(1'b0, 3'h3, 3'h5, 1'b0, 10'h000), 16'h0808, 1'b1);
        lsa(ls(1'b0, 3'h3, 3'h7, 1'b0, 10'h000), 16'h0000, 1'b0);
        lsa(ls(1'b0, 3'h3, 3'h0, 1'b0, 10'h000), 16'h1013, 1'b1);
        issue(agu(2'h3, 3'h0, 16'h0003));
        issue(agu(2'h1, 3'h6, 16'h0001));
        lsa(ls(1'b0, 3'h6, 3'h4, 1'b1, 10'h000), 16'h0003, 1'b1);
        lsa(ls(1'b0, 3'h6, 3'h0, 1'b1, 10'h000), 16'h0000, 1'b1);
        u_dic_fetch_model.idle();
        $display("test pointers done");
    endtask : t_ptr
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(negedge i_ref_clk);
        chk(o_ready === 1'b0 && o_valid === 1'b0 && o_class === DIC_CLS_CTL, "reset state");
        i_nrst = 1'b1;
        $display("test reset done");
        t_classes();
        t_branch();
        t_bin();
        t_ptr();
        give_verdict();
    end
endmodule : test_dic_decode_top
`default_nettype wire
